// >>> design/pmc_regs.sv
// PHY basic control and status registers behind the management interface.
// Assumes the media side supplies negotiation results and live status.
//
// Operation
// RULE_01: Autoneg enabled ignores force bits; disabled, force bits set speed, duplex.
// RULE_02: Power-down bit lowers power; management accesses still work.
// RULE_03: Power-down drops the link and stops all MAC-side data paths.
// RULE_04: Isolate ignores MAC inputs and floats all MAC outputs.
// RULE_05: Restart bit restarts autonegotiation, ignored while autoneg disabled.
// RULE_06: Restart bit clears itself once the new negotiation has begun.
// RULE_07: Forced duplex, 0 half 1 full, only counts with autoneg off.
// RULE_08: Loop-back mode disregards the forced duplex bit.
// RULE_09: Collision test copies transmit enable onto collision quickly.
// RULE_10: Control bit 6 is the forced speed code MSB.
// RULE_11: Control bits 5:0 are reserved, read-only, read as zero.
// RULE_12: Status register is read-only; writes change nothing.
// RULE_13: Status bit 15 reports 100BASE-T4 ability.
// RULE_14: Status bit 14 reports 100BASE-TX full duplex ability.
// RULE_15: Status bit 13 reports 100BASE-TX half duplex ability.
// RULE_16: Status bit 12 reports 10BASE-T full duplex ability.
// RULE_17: Status bit 11 reports 10BASE-T half duplex ability.
// RULE_18: Speed code 0 is 10, 1 is 100, 2 is 1000 Mbit/s; 3 reserved.
// RULE_19: Reset bit restores defaults, ends links, then clears itself.
// RULE_20: Loop-back returns transmit data to receive, sends nothing out.
// RULE_21: Status bit 2 shows link up, latches low until read.
// RULE_22: Latched-high status bits hold until the status register is read.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs #(
  parameter logic [pmc_pkg::ABILITY_W-1:0] ABILITIES =
    pmc_pkg::ABILITY_DEFAULT,
  parameter int DATA_W = pmc_pkg::MII_DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [pmc_pkg::PHY_ADDR_W-1:0] phyAddr,
  input wire logic [pmc_pkg::SPEED_W-1:0] anSpeed,
  input wire logic anFullDuplex,
  input wire logic anComplete,
  input wire logic anStartAck,
  input wire logic linkLive,
  input wire logic remoteFault,
  input wire logic jabber,
  output logic autonegEnable,
  output logic anRestartReq,
  output logic powerDown,
  output logic loopBack,
  output logic isolate,
  output logic phyReset,
  output logic linkEnable,
  output logic [pmc_pkg::SPEED_W-1:0] opSpeed,
  output logic opFullDuplex,
  input wire logic macTxEn,
  input wire logic [DATA_W-1:0] macTxData,
  output logic macRxDv,
  output logic [DATA_W-1:0] macRxData,
  output logic macCrs,
  output logic macCol,
  output logic macOe,
  input wire logic mediaRxDv,
  input wire logic [DATA_W-1:0] mediaRxData,
  input wire logic mediaCrs,
  input wire logic mediaCol,
  output logic mediaTxEn,
  output logic [DATA_W-1:0] mediaTxData
);
  import pmc_pkg::*;

  function automatic logic hits(input logic [REG_ADDR_W-1:0] addr,
                                input logic [REG_ADDR_W-1:0] target);
    hits = (addr == target);
  endfunction

  logic rdStrobe;
  logic wrStrobe;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [REG_W-1:0] wrData;
  logic [REG_W-1:0] rdData_q;

  logic rstBit_q;
  logic lb_q;
  logic ssl_q;
  logic autoneg_enable_q;
  logic pd_q;
  logic iso_q;
  logic autoneg_restart_q;
  logic forced_duplex_q;
  logic col_q;
  logic ssm_q;
  logic [RST_CNT_W-1:0] rstCnt_q;
  logic linkLatch_q;
  logic rfLatch_q;
  logic jabLatch_q;
  logic speedValid_q;

  logic ctrlWrite;
  logic statusRead;
  logic resetDone;
  logic [SPEED_W-1:0] forcedSpeed;
  logic [REG_W-1:0] ctrlWord;
  logic [REG_W-1:0] statWord;

  pmc_mdio_frame u_frame (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .phyAddr(phyAddr),
    .rdData(rdData_q),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .rdStrobe(rdStrobe),
    .wrStrobe(wrStrobe),
    .regAddr(regAddr),
    .wrData(wrData)
  );

  pmc_mac_gate #(
    .DATA_W(DATA_W)
  ) u_gate (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .isolate(iso_q),
    .powerDown(pd_q),
    .loopBack(lb_q),
    .colTest(col_q),
    .macTxEn(macTxEn),
    .macTxData(macTxData),
    .mediaRxDv(mediaRxDv),
    .mediaRxData(mediaRxData),
    .mediaCrs(mediaCrs),
    .mediaCol(mediaCol),
    .macRxDv(macRxDv),
    .macRxData(macRxData),
    .macCrs(macCrs),
    .macCol(macCol),
    .macOe(macOe),
    .mediaTxEn(mediaTxEn),
    .mediaTxData(mediaTxData)
  );

  // Writes land only on the control register; status writes fall away
  assign ctrlWrite = wrStrobe & hits(regAddr, REG_CTRL) & ~rstBit_q; // RULE_12
  assign statusRead = rdStrobe & hits(regAddr, REG_STAT);
  // Gated by ce so a paused clock enable cannot end the reset early
  assign resetDone = ce & rstBit_q & (rstCnt_q == SOFT_RESET_LAST);
  assign forcedSpeed = {ssm_q, ssl_q}; // RULE_10

  // Control fields; a write asking for reset only arms the reset sequence
  always_ff @(posedge clk) begin
    if (rst || resetDone) begin
      lb_q <= CTRL_RESET_VAL[CTRL_LB]; // RULE_19
      ssl_q <= CTRL_RESET_VAL[CTRL_SSL];
      autoneg_enable_q <= CTRL_RESET_VAL[CTRL_AUTONEG_ENABLE];
      pd_q <= CTRL_RESET_VAL[CTRL_PD];
      iso_q <= CTRL_RESET_VAL[CTRL_ISO];
      forced_duplex_q <= CTRL_RESET_VAL[CTRL_FORCED_DUPLEX];
      col_q <= CTRL_RESET_VAL[CTRL_COL];
      ssm_q <= CTRL_RESET_VAL[CTRL_SSM];
    end else if (ce && ctrlWrite && !wrData[CTRL_RST]) begin
      lb_q <= wrData[CTRL_LB];
      ssl_q <= wrData[CTRL_SSL];
      autoneg_enable_q <= wrData[CTRL_AUTONEG_ENABLE];
      pd_q <= wrData[CTRL_PD]; // RULE_02
      iso_q <= wrData[CTRL_ISO]; // RULE_04
      forced_duplex_q <= wrData[CTRL_FORCED_DUPLEX];
      col_q <= wrData[CTRL_COL]; // RULE_09
      ssm_q <= wrData[CTRL_SSM]; // RULE_10
    end
  end

  // Self-clearing reset bit held for a fixed time while the PHY resets
  always_ff @(posedge clk) begin
    if (rst) begin
      rstBit_q <= 1'b0;
      rstCnt_q <= '0;
    end else if (ce) begin
      if (resetDone) begin
        rstBit_q <= 1'b0; // RULE_19
        rstCnt_q <= '0;
      end else if (rstBit_q) begin
        rstCnt_q <= rstCnt_q + 1'b1;
      end else if (ctrlWrite && wrData[CTRL_RST]) begin
        rstBit_q <= 1'b1; // RULE_19
        rstCnt_q <= '0;
      end
    end
  end

  // Restart request: a new write beats an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (rst || resetDone) begin
      autoneg_restart_q <= 1'b0;
    end else if (ce) begin
      if (ctrlWrite && !wrData[CTRL_RST] && wrData[CTRL_AUTONEG_RESTART]
          && wrData[CTRL_AUTONEG_ENABLE]) begin
        autoneg_restart_q <= 1'b1; // RULE_05
      end else if (anStartAck || !autoneg_enable_q) begin
        autoneg_restart_q <= 1'b0; // RULE_06
      end
    end
  end

  // Operating speed and duplex
  always_ff @(posedge clk) begin
    if (rst) begin
      opSpeed <= {CTRL_RESET_VAL[CTRL_SSM], CTRL_RESET_VAL[CTRL_SSL]};
      opFullDuplex <= CTRL_RESET_VAL[CTRL_FORCED_DUPLEX];
      speedValid_q <= 1'b1;
    end else if (ce) begin
      if (autoneg_enable_q) begin
        opSpeed <= anSpeed; // RULE_01
        opFullDuplex <= anFullDuplex;
        speedValid_q <= 1'b1;
      end else begin
        // Reserved code leaves the last valid speed in place
        if (forcedSpeed != SPEED_RSVD) begin
          opSpeed <= forcedSpeed; // RULE_18
          speedValid_q <= 1'b1;
        end else begin
          speedValid_q <= 1'b0;
        end
        // With autoneg disabled, loop-back always runs full duplex
        opFullDuplex <= lb_q ? 1'b1 : forced_duplex_q; // RULE_07 RULE_08
      end
    end
  end

  // Data link enable; drops one cycle after the power-down or soft reset bit sets
  always_ff @(posedge clk) begin
    if (rst) begin
      linkEnable <= 1'b0;
    end else if (ce) begin
      linkEnable <= ~pd_q & ~rstBit_q; // RULE_03 RULE_19
    end
  end

  // Latched status: event wins over the clear that a read performs
  always_ff @(posedge clk) begin
    if (rst || resetDone) begin
      linkLatch_q <= STAT_RESET_VAL[STAT_LS];
      rfLatch_q <= STAT_RESET_VAL[STAT_RF];
      jabLatch_q <= STAT_RESET_VAL[STAT_JD];
    end else if (ce) begin
      if (statusRead) begin
        linkLatch_q <= linkLive; // RULE_21
        rfLatch_q <= remoteFault; // RULE_22
        jabLatch_q <= jabber;
      end else begin
        if (!linkLive) begin
          linkLatch_q <= 1'b0; // RULE_21
        end
        if (remoteFault) begin
          rfLatch_q <= 1'b1; // RULE_22
        end
        if (jabber) begin
          jabLatch_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    ctrlWord = {rstBit_q, lb_q, ssl_q, autoneg_enable_q, pd_q, iso_q, autoneg_restart_q, forced_duplex_q,
                col_q, ssm_q, CTRL_RES_BITS}; // RULE_11
  end

  always_comb begin
    statWord = STAT_RESET_VAL & STAT_FIXED_MASK;
    // RULE_13 RULE_14 RULE_15 RULE_16 RULE_17
    statWord[STAT_ABIL_HI:STAT_ABIL_LO] = ABILITIES;
    statWord[STAT_ANOK] = anComplete;
    statWord[STAT_RF] = rfLatch_q;
    statWord[STAT_LS] = linkLatch_q;
    statWord[STAT_JD] = jabLatch_q;
  end

  // Read data is captured at the read strobe, before latches update
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (ce && rdStrobe) begin
      if (hits(regAddr, REG_CTRL)) begin
        rdData_q <= ctrlWord;
      end else if (hits(regAddr, REG_STAT)) begin
        rdData_q <= statWord;
      end else begin
        rdData_q <= '0;
      end
    end
  end

  assign autonegEnable = autoneg_enable_q;
  assign anRestartReq = autoneg_restart_q;
  assign powerDown = pd_q;
  assign loopBack = lb_q;
  assign isolate = iso_q;
  assign phyReset = rstBit_q;
endmodule
`default_nettype wire

// >>> design/pmc_pkg.sv
// Constants shared by the PHY management control/status block.
// Assumes a 16-bit management register file reached over MDC/MDIO.
package pmc_pkg;

  localparam int REG_W = 16;
  localparam int REG_ADDR_W = 5;
  localparam int PHY_ADDR_W = 5;
  localparam int MII_DATA_W = 4;
  localparam int SPEED_W = 2;
  localparam int ABILITY_W = 5;
  localparam int CNT_W = 5;

  // Register offsets
  localparam logic [REG_ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [REG_ADDR_W-1:0] REG_STAT = 5'h01;

  // Control register fields
  localparam int CTRL_RST = 15;
  localparam int CTRL_LB = 14;
  localparam int CTRL_SSL = 13;
  localparam int CTRL_AUTONEG_ENABLE = 12;
  localparam int CTRL_PD = 11;
  localparam int CTRL_ISO = 10;
  localparam int CTRL_AUTONEG_RESTART = 9;
  localparam int CTRL_FORCED_DUPLEX = 8;
  localparam int CTRL_COL = 7;
  localparam int CTRL_SSM = 6;
  localparam logic [REG_W-1:0] CTRL_RESET_VAL = 16'h1040;
  localparam logic [5:0] CTRL_RES_BITS = 6'h00;

  // Status register fields
  localparam int STAT_ABIL_HI = 15;
  localparam int STAT_ABIL_LO = 11;
  localparam int STAT_ANOK = 5;
  localparam int STAT_RF = 4;
  localparam int STAT_LS = 2;
  localparam int STAT_JD = 1;
  localparam logic [REG_W-1:0] STAT_RESET_VAL = 16'h7949;
  // Constant bits 10:0 apart from the live and latched ones
  localparam logic [REG_W-1:0] STAT_FIXED_MASK = 16'h07C9;
  localparam logic [ABILITY_W-1:0] ABILITY_DEFAULT = 5'h0F;

  // Forced speed codes
  localparam logic [SPEED_W-1:0] SPEED_10 = 2'h0;
  localparam logic [SPEED_W-1:0] SPEED_100 = 2'h1;
  localparam logic [SPEED_W-1:0] SPEED_1000 = 2'h2;
  localparam logic [SPEED_W-1:0] SPEED_RSVD = 2'h3;

  // Management frame
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [CNT_W-1:0] HDR_LAST = 5'h0B;
  localparam logic [CNT_W-1:0] TA_LAST = 5'h01;
  localparam logic [CNT_W-1:0] DATA_BITS = 5'h10;
  localparam logic [CNT_W-1:0] DATA_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] SKIP_LAST = 5'h11;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYC =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] SOFT_RESET_LAST =
    RST_CNT_W'(SOFT_RESET_CYC - 1);

endpackage

// >>> design/pmc_mdio_frame.sv
// Management frame engine: parses read/write frames on MDC/MDIO.
// Assumes MDC and MDIO are synchronous to clk and much slower than it.
`timescale 1ns/1ps
`default_nettype none
module pmc_mdio_frame (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdioIn,
  input wire logic [pmc_pkg::PHY_ADDR_W-1:0] phyAddr,
  input wire logic [pmc_pkg::REG_W-1:0] rdData,
  output logic mdioOut,
  output logic mdioOe,
  output logic rdStrobe,
  output logic wrStrobe,
  output logic [pmc_pkg::REG_ADDR_W-1:0] regAddr,
  output logic [pmc_pkg::REG_W-1:0] wrData
);
  import pmc_pkg::*;

  typedef enum logic [2:0] {
    F_IDLE, F_START, F_HDR, F_RTA, F_RDATA, F_WTA, F_WDATA, F_SKIP
  } pmc_frame_state_t;

  pmc_frame_state_t state_q;
  logic mdcPrev_q;
  logic sawOne_q;
  logic [CNT_W-1:0] cnt_q;
  logic [10:0] hdr_q;
  logic [REG_W-1:0] shift_q;
  logic mdcRise;
  logic [11:0] hdrFull;

  assign mdcRise = mdc & ~mdcPrev_q;
  assign hdrFull = {hdr_q, mdioIn};

  always_ff @(posedge clk) begin
    if (rst) begin
      mdcPrev_q <= 1'b0;
    end else if (ce) begin
      mdcPrev_q <= mdc;
    end
  end

  // No preamble needed: an idle one followed by start bits opens a frame
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= F_IDLE;
      sawOne_q <= 1'b0;
      cnt_q <= '0;
      hdr_q <= '0;
      shift_q <= '0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
      rdStrobe <= 1'b0;
      wrStrobe <= 1'b0;
      regAddr <= '0;
      wrData <= '0;
    end else if (ce) begin
      rdStrobe <= 1'b0;
      wrStrobe <= 1'b0;
      if (mdcRise) begin
        unique case (state_q)
          F_IDLE: begin
            if (mdioIn) begin
              sawOne_q <= 1'b1;
            end else if (sawOne_q) begin
              sawOne_q <= 1'b0;
              state_q <= F_START;
            end
          end
          F_START: begin
            cnt_q <= '0;
            state_q <= mdioIn ? F_HDR : F_IDLE;
          end
          F_HDR: begin
            hdr_q <= hdrFull[10:0];
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == HDR_LAST) begin
              cnt_q <= '0;
              regAddr <= hdrFull[4:0];
              if (hdrFull[9:5] != phyAddr) begin
                state_q <= F_SKIP;
              end else if (hdrFull[11:10] == OP_READ) begin
                rdStrobe <= 1'b1;
                state_q <= F_RTA;
              end else if (hdrFull[11:10] == OP_WRITE) begin
                state_q <= F_WTA;
              end else begin
                state_q <= F_IDLE;
              end
            end
          end
          F_RTA: begin
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
            shift_q <= rdData;
            cnt_q <= '0;
            state_q <= F_RDATA;
          end
          F_RDATA: begin
            if (cnt_q == DATA_BITS) begin
              mdioOe <= 1'b0;
              mdioOut <= 1'b0;
              state_q <= F_IDLE;
            end else begin
              mdioOut <= shift_q[REG_W-1];
              shift_q <= {shift_q[REG_W-2:0], 1'b0};
              cnt_q <= cnt_q + 1'b1;
            end
          end
          F_WTA: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == TA_LAST) begin
              cnt_q <= '0;
              state_q <= F_WDATA;
            end
          end
          F_WDATA: begin
            shift_q <= {shift_q[REG_W-2:0], mdioIn};
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == DATA_LAST) begin
              wrData <= {shift_q[REG_W-2:0], mdioIn};
              wrStrobe <= 1'b1;
              state_q <= F_IDLE;
            end
          end
          F_SKIP: begin
            // Frames for other addresses are stepped over, not decoded
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == SKIP_LAST) begin
              state_q <= F_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/pmc_mac_gate.sv
// MAC-side data path gating: isolate, power-down, loop-back, collision test.
// Assumes nibble-wide MII data synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pmc_mac_gate #(
  parameter int DATA_W = pmc_pkg::MII_DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic isolate,
  input wire logic powerDown,
  input wire logic loopBack,
  input wire logic colTest,
  input wire logic macTxEn,
  input wire logic [DATA_W-1:0] macTxData,
  input wire logic mediaRxDv,
  input wire logic [DATA_W-1:0] mediaRxData,
  input wire logic mediaCrs,
  input wire logic mediaCol,
  output logic macRxDv,
  output logic [DATA_W-1:0] macRxData,
  output logic macCrs,
  output logic macCol,
  output logic macOe,
  output logic mediaTxEn,
  output logic [DATA_W-1:0] mediaTxData
);
  import pmc_pkg::*;

  always_ff @(posedge clk) begin
    if (rst) begin
      macOe <= 1'b0;
    end else if (ce) begin
      macOe <= ~isolate; // RULE_04
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      macRxDv <= 1'b0;
      macRxData <= '0;
      macCrs <= 1'b0;
      macCol <= 1'b0;
      mediaTxEn <= 1'b0;
      mediaTxData <= '0;
    end else if (ce) begin
      if (isolate || powerDown) begin
        // Inputs ignored and nothing moves in either direction
        macRxDv <= 1'b0; // RULE_03
        macRxData <= '0;
        macCrs <= 1'b0;
        macCol <= 1'b0; // RULE_04
        mediaTxEn <= 1'b0;
        mediaTxData <= '0;
      end else if (loopBack) begin
        macRxDv <= macTxEn; // RULE_20
        macRxData <= macTxData;
        macCrs <= macTxEn;
        macCol <= colTest & macTxEn; // RULE_09
        mediaTxEn <= 1'b0; // RULE_20
        mediaTxData <= '0;
      end else begin
        macRxDv <= mediaRxDv;
        macRxData <= mediaRxData;
        macCrs <= mediaCrs;
        // One register stage is the least latency this path allows
        macCol <= colTest ? macTxEn : mediaCol; // RULE_09
        mediaTxEn <= macTxEn;
        mediaTxData <= macTxData;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/pmc_regs_asserts.sv
// Port checker for the control/status block.
// Assumes the reset timer runs only on cycles with ce high.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic isolate,
  input wire logic powerDown,
  input wire logic loopBack,
  input wire logic autonegEnable,
  input wire logic anRestartReq,
  input wire logic anStartAck,
  input wire logic phyReset,
  input wire logic linkEnable,
  input wire logic [pmc_pkg::SPEED_W-1:0] opSpeed,
  input wire logic opFullDuplex,
  input wire logic [pmc_pkg::SPEED_W-1:0] anSpeed,
  input wire logic anFullDuplex,
  input wire logic macOe,
  input wire logic macRxDv,
  input wire logic [3:0] macRxData,
  input wire logic macCrs,
  input wire logic macCol,
  input wire logic macTxEn,
  input wire logic [3:0] macTxData,
  input wire logic mediaTxEn
);
  import pmc_pkg::*;
  logic [7:0] holdCnt_q;
  always_ff @(posedge clk) begin
    if (rst || !phyReset) begin
      holdCnt_q <= 8'h00;
    end else if (ce) begin
      holdCnt_q <= holdCnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_AN_RESOLVE: assert property ($past(autonegEnable && !rst) |->
    opSpeed == $past(anSpeed) && opFullDuplex == $past(anFullDuplex))
    else $error("resolved mode does not follow negotiation");
  AST_SPEED_CODE: assert property (opSpeed != SPEED_RSVD)
    else $error("reserved speed code in use");
  AST_LB_DUPLEX: assert property (
    $past(loopBack && !autonegEnable && !rst) |-> opFullDuplex)
    else $error("loop-back duplex wrong");
  AST_ISO_FLOAT: assert property ($past(isolate && !rst) |->
    !macOe && !macRxDv && !macCrs && !macCol)
    else $error("isolated outputs still driven");
  AST_PD_QUIET: assert property ($past(powerDown && !rst) |->
    !linkEnable && !macRxDv && !mediaTxEn) else $error("power-down leak");
  AST_LB_ECHO: assert property (
    $past(loopBack && !isolate && !powerDown && !rst) |-> !mediaTxEn &&
    macRxDv == $past(macTxEn) && macRxData == $past(macTxData))
    else $error("loop-back data wrong");
  AST_RESTART_AN: assert property (
    $rose(anRestartReq) |-> autonegEnable)
    else $error("restart raised without negotiation");
  AST_RESTART_CLR: assert property (anRestartReq && anStartAck |=>
    !anRestartReq) else $error("restart request not cleared");
  AST_SRST_LEN: assert property ($fell(phyReset) |->
    holdCnt_q == 8'(SOFT_RESET_CYC)) else $error("soft reset length wrong");
  AST_SRST_LINK: assert property (
    $past(phyReset && !rst) |-> !linkEnable)
    else $error("link kept during soft reset");
  cover property ($fell(phyReset));
  cover property (anRestartReq && anStartAck);
  cover property ($past(loopBack) && macRxDv);
endmodule
bind pmc_regs pmc_regs_asserts u_chk (.*);
`default_nettype wire

// >>> tb/pmc_mgmt_model.sv
// Station manager model: clocks MDC and sends management frames.
// Assumes a pull-up on MDIO and clk seven times MDC.
`timescale 1ns/1ps
`default_nettype none
module pmc_mgmt_model #(
  parameter logic [4:0] PHY = 5'h03
) (
  input wire logic clk,
  output var logic mdc,
  output wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  import pmc_pkg::*;
  logic drive = 1'b0;
  logic level = 1'b1;
  initial mdc = 1'b0;
  // Released wire settles at the pull-up level
  assign mdioIn = drive ? level : (mdioOe ? mdioOut : 1'b1);
  // MDC idles low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [32:0] bits;
    bits = {3'h5, op, PHY, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 33; i++) begin
      @(negedge clk);
      mdc = 1'b0;
      drive = (op == OP_WRITE) || (i < 15);
      level = bits[32-i];
      repeat (3) @(negedge clk);
      // Value launched at the previous rise, read just before the next
      if (i > 16) rd = {rd[14:0], mdioIn};
      mdc = 1'b1;
      repeat (3) @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0;
    drive = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_pmc_regs.sv
// Bench for the control/status block with a station manager model.
// Assumes pmc_mgmt_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_pmc_regs;
  import pmc_pkg::*;
  logic clk, rst, ce, mdc, mdioIn, mdioOut, mdioOe;
  logic [4:0] phyAddr;
  logic [1:0] anSpeed, opSpeed;
  logic anFullDuplex, anComplete, anStartAck, linkLive, remoteFault, jabber;
  logic autonegEnable, anRestartReq, powerDown, loopBack, isolate, phyReset;
  logic linkEnable, opFullDuplex, macTxEn, macRxDv, macCrs, macCol, macOe;
  logic mediaRxDv, mediaCrs, mediaCol, mediaTxEn;
  logic [3:0] macTxData, macRxData, mediaRxData, mediaTxData;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  pmc_regs dut (.*);
  pmc_mgmt_model mgr (.clk(clk), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe(mdioOe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgr.frame(OP_WRITE, ra, d, x);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    mgr.frame(OP_READ, ra, 16'h0000, d);
    chk(d, exp);
  endtask
  task automatic t_reset;
    rd(REG_CTRL, CTRL_RESET_VAL);
    rd(REG_STAT, 16'h7949);
    rd(5'h1F, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_forced;
    logic [15:0] w;
    logic [1:0] sp;
    for (int c = 0; c < 6; c++) begin
      sp = 2'(c % 3);
      // Reserved bits always written as zero
      w = 16'h0000;
      w[CTRL_SSL] = sp[0];
      w[CTRL_SSM] = sp[1];
      w[CTRL_FORCED_DUPLEX] = (c > 2);
      wr(REG_CTRL, w);
      chk({14'h0, opSpeed}, {14'h0, sp});
      chk({15'h0, opFullDuplex}, {15'h0, w[CTRL_FORCED_DUPLEX]});
      rd(REG_CTRL, w & 16'hFFC0);
    end
    wr(REG_CTRL, 16'h2140);
    chk({14'h0, opSpeed}, {14'h0, SPEED_1000});
    wr(REG_CTRL, 16'h4000);
    chk({15'h0, opFullDuplex}, 16'h0001);
    $display("test forced done");
  endtask
  task automatic t_autoneg;
    anSpeed = SPEED_100;
    anFullDuplex = 1'b1;
    wr(REG_CTRL, 16'h1040);
    chk({13'h0, opSpeed, opFullDuplex}, 16'h0003);
    wr(REG_CTRL, 16'h1240);
    chk({15'h0, anRestartReq}, 16'h0001);
    rd(REG_CTRL, 16'h1240);
    anStartAck = 1'b1;
    @(negedge clk);
    anStartAck = 1'b0;
    @(negedge clk);
    chk({15'h0, anRestartReq}, 16'h0000);
    rd(REG_CTRL, 16'h1040);
    wr(REG_CTRL, 16'h0200);
    chk({15'h0, anRestartReq}, 16'h0000);
    $display("test autoneg done");
  endtask
  task automatic t_status;
    wr(REG_STAT, 16'h0000);
    rd(REG_STAT, 16'h7949);
    linkLive = 1'b1;
    rd(REG_STAT, 16'h7949);
    rd(REG_STAT, 16'h794D);
    linkLive = 1'b0;
    @(negedge clk);
    linkLive = 1'b1;
    remoteFault = 1'b1;
    jabber = 1'b1;
    @(negedge clk);
    remoteFault = 1'b0;
    jabber = 1'b0;
    rd(REG_STAT, 16'h795B);
    anComplete = 1'b1;
    rd(REG_STAT, 16'h796D);
    $display("test status done");
  endtask
  task automatic t_modes;
    macTxEn = 1'b1;
    macTxData = 4'hA;
    mediaRxDv = 1'b1;
    mediaRxData = 4'h5;
    wr(REG_CTRL, 16'h0400);
    chk({12'h0, macOe, macRxDv, mediaTxEn, macCol}, 16'h0000);
    wr(REG_CTRL, 16'h0800);
    chk({13'h0, linkEnable, macRxDv, mediaTxEn}, 16'h0000);
    rd(REG_CTRL, 16'h0800);
    wr(REG_CTRL, 16'h0080);
    chk({6'h0, macOe, macCol, mediaTxData, macRxData}, 16'h03A5);
    wr(REG_CTRL, 16'h0000);
    mediaCol = 1'b1;
    macTxEn = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, macCol}, 16'h0001);
    macTxEn = 1'b1;
    macTxData = 4'h3;
    wr(REG_CTRL, 16'h4000);
    chk({10'h0, mediaTxEn, macRxDv, macRxData}, 16'h0013);
    $display("test modes done");
  endtask
  task automatic t_softreset;
    wr(REG_CTRL, 16'h8000);
    chk({14'h0, phyReset, linkEnable}, 16'h0002);
    // A paused clock enable must hold the reset timer
    ce = 1'b0;
    repeat (20) @(negedge clk);
    chk({15'h0, phyReset}, 16'h0001);
    ce = 1'b1;
    repeat (24) @(negedge clk);
    chk({15'h0, phyReset}, 16'h0000);
    rd(REG_CTRL, CTRL_RESET_VAL);
    $display("test softreset done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    {rst, ce} = 2'h3;
    phyAddr = 5'h03;
    {anSpeed, anFullDuplex, anComplete, anStartAck} = 5'h00;
    {linkLive, remoteFault, jabber, macTxEn, macTxData} = 8'h00;
    {mediaRxDv, mediaRxData, mediaCrs, mediaCol} = 7'h00;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset;
    t_forced;
    t_autoneg;
    t_status;
    t_modes;
    t_softreset;
    print_verdict;
  end
endmodule
`default_nettype wire
